// *** core/refclk_cfg.svh ***
// Functional notes
// - divider clocked only by the system clock
// - crystal modes keep reference off shared pin
// - quarter clock enable puts clk/4 on pin
// - block halts while the device sleeps
// - outputs hold level during sleep (undivided clock held low), resume after
// - control bit 6 routes reference onto pin
// - divider field divides by two to the power
// - divide-by-two quarter duties may be inexact
// - no divided clock while module enable clear
// - slew limit bit drives pin slew, resets one
`ifndef REFCLK_CFG_SVH
`define REFCLK_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses on the register bus)
// ----------------------------------------------------------------
`define REFCLK_CTRL_OFFSET   12'h000
`define REFCLK_STATUS_OFFSET 12'h004

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define REFCLK_CTRL_RESET    8'h30
`define REFCLK_EN_BIT        7
`define REFCLK_OE_BIT        6
`define REFCLK_SLEW_BIT      5
`define REFCLK_DUTY_HI       4
`define REFCLK_DUTY_LO       3
`define REFCLK_DIV_HI        2
`define REFCLK_DIV_LO        0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define REFCLK_ST_LEVEL_BIT   0
`define REFCLK_ST_PINREF_BIT  1
`define REFCLK_ST_QUARTER_BIT 2
`define REFCLK_ST_XTAL_BIT    3

// ----------------------------------------------------------------
// encodings and counts
// ----------------------------------------------------------------
`define REFCLK_DUTY_ZERO     2'h0
`define REFCLK_DIV_BYPASS    3'h0
`define REFCLK_DIV_BY_TWO    3'h1
`define REFCLK_QUARTER_BIT   1

`endif

// *** core/refclk_pkg.sv ***
package refclk_pkg;

   // register slave state, one word of read data plus the control byte
   typedef struct packed {
      logic        ready;   // access phase answer
      logic        slvErr;  // unmapped address answer
      logic [31:0] rdata;   // captured read data
      logic [7:0]  ctrl;    // control register contents
   } apbState_s;

   // divider and pin state of the top module
   typedef struct packed {
      logic [6:0] divCount;     // free-running divider counter
      logic [1:0] quarterCount; // clk/4 generator
      logic       refLevel;     // divided reference level
      logic       bypass;       // undivided path selected
      logic       pinLevel;     // level driven on the pin
      logic       pinBypass;    // pin carries the undivided clock
      logic       pinOeN;       // low while the pin is driven
      logic       slew;         // slew limit to the pad
   } refclkState_s;

endpackage

// *** core/sync_two_ff.sv ***
`timescale 1ns/1ns

// two-flop synchroniser for pin-level configuration straps
module sync_two_ff #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] stage1; // metastable stage, read only by stage2
      logic [WIDTH-1:0] stage2; // settled copy
   } syncState_s;

   syncState_s state_ff;
   syncState_s nxt_state;

   // next state: shift one stage per enabled edge
   always_comb begin
      nxt_state = state_ff;
      if (ce) begin
         nxt_state.stage1 = asyncIn;
         nxt_state.stage2 = state_ff.stage1;
      end
   end

   // register the whole state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign syncOut = state_ff.stage2;

endmodule // sync_two_ff

// *** core/refclk_apb_regs.sv ***
`timescale 1ns/1ns
`include "refclk_cfg.svh"

// apb slave holding the control register and a read-only status word
module refclk_apb_regs (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [7:0]  statusIn,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [7:0]  ctrlOut
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   refclk_pkg::apbState_s state_ff;
   refclk_pkg::apbState_s nxt_state;
   logic                  isCtrl;   // address hits control
   logic                  isStatus; // address hits status

   assign isCtrl   = (paddr == `REFCLK_CTRL_OFFSET);
   assign isStatus = (paddr == `REFCLK_STATUS_OFFSET);

   // no wait state: answer is prepared in setup, shown in the first access cycle
   always_comb begin
      nxt_state = state_ff;
      if (ce) begin
         nxt_state.ready  = 1'b0;
         nxt_state.slvErr = 1'b0;
         if (psel && !penable) begin
            // setup phase: decode and latch read data
            nxt_state.ready  = 1'b1;
            nxt_state.slvErr = !(isCtrl || isStatus);
            if (isCtrl) begin
               nxt_state.rdata = {24'h000000, state_ff.ctrl};
            end else if (isStatus) begin
               nxt_state.rdata = {24'h000000, statusIn};
            end else begin
               nxt_state.rdata = 32'h00000000;
            end
         end else if (psel && penable && state_ff.ready) begin
            // completing edge: write lands here and only here
            if (pwrite && isCtrl) begin
               nxt_state.ctrl = pwdata[7:0];
            end
         end
      end
   end

   // register the whole state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff      <= '0;
         state_ff.ctrl <= `REFCLK_CTRL_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign prdata  = state_ff.rdata;
   assign pready  = state_ff.ready;
   assign pslverr = state_ff.slvErr;
   assign ctrlOut = state_ff.ctrl;

endmodule // refclk_apb_regs

// *** core/reference_clock_divider.sv ***
`timescale 1ns/1ns
`include "refclk_cfg.svh"

// reference clock output: power-of-two divider with duty select,
// shared pin arbitration and a feed to the internal modulator
module reference_clock_divider (
   input  wire logic        clk,                     // system clock, 20 MHz
   input  wire logic        reset,                   // async, active high
   input  wire logic        ce,                      // low freezes all state (sleep)
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lowPowerCrystalMode,     // strap, async
   input  wire logic        standardCrystalMode,     // strap, async
   input  wire logic        highSpeedCrystalMode,    // strap, async
   input  wire logic        quarterClockOutputEnable, // strap, async
   output logic             referenceClockPinOut,    // pin data
   output logic             referenceClockPinOeN,    // low while driven
   output logic             slewLimitEnable,         // to the pad
   output logic             modulatorClock           // internal reference feed
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   refclk_pkg::refclkState_s state_ff;      // every flop of this module
   refclk_pkg::refclkState_s nxt_state;     // next value of that state
   logic [7:0]               ctrl;          // control register from the slave
   logic [7:0]               statusWord;    // read-only view for software
   logic [3:0]               strapRaw;      // configuration straps, raw
   logic [3:0]               strapSync;     // straps after two flops
   logic                     moduleEn;      // divider runs while set
   logic                     pinRouteEn;    // reference wanted on the pin
   logic                     slewBit;       // requested slew limiting
   logic [1:0]               dutySel;       // high-time select
   logic [2:0]               divSel;        // power-of-two divider select
   logic                     xtalAny;       // pin taken by a crystal oscillator
   logic                     quarterEn;     // pin taken by the quarter clock
   logic [7:0]               period;        // divided period in system clocks
   logic [7:0]               phase;         // position inside the period
   logic [9:0]               scaledPhase;   // phase times four
   logic [9:0]               threshold;     // period times duty code
   logic                     refNext;       // divided level for next cycle
   logic                     bypassNext;    // undivided path for next cycle
   logic                     quarterLevel;  // current quarter clock level
   logic                     pinCarriesRef; // status: reference reaches pin

   // ----------------------------------------------------------------
   // strap synchronisers
   // ----------------------------------------------------------------
   // straps come from configuration fuses outside this clock domain,
   // so every one passes two flops before any decode reads it;
   // bit order: low-power, standard, high-speed, quarter clock
   assign strapRaw = {quarterClockOutputEnable,
                      highSpeedCrystalMode,
                      standardCrystalMode,
                      lowPowerCrystalMode};

   sync_two_ff #(
      .WIDTH (4)
   ) strapSyncer (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .asyncIn (strapRaw),
      .syncOut (strapSync)
   );

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   // the slave freezes with the rest of the block, so no register
   // access completes while the system clock is stopped
   refclk_apb_regs regs (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .statusIn (statusWord),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .ctrlOut  (ctrl)
   );

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   assign moduleEn     = ctrl[`REFCLK_EN_BIT];
   assign pinRouteEn   = ctrl[`REFCLK_OE_BIT];
   assign slewBit      = ctrl[`REFCLK_SLEW_BIT];
   assign dutySel      = ctrl[`REFCLK_DUTY_HI:`REFCLK_DUTY_LO];
   assign divSel       = ctrl[`REFCLK_DIV_HI:`REFCLK_DIV_LO];
   // any crystal mode claims the shared pin as an oscillator input
   assign xtalAny      = |strapSync[2:0];
   // the quarter clock function outranks the reference output
   assign quarterEn    = strapSync[3];
   assign quarterLevel = state_ff.quarterCount[`REFCLK_QUARTER_BIT];

   // ----------------------------------------------------------------
   // divided level
   // ----------------------------------------------------------------
   // the period is a power of two, so the phase is just the low bits
   // of the free-running counter; comparing four times the phase with
   // period times duty code avoids any divider in the datapath
   always_comb begin
      period      = 8'h01 << divSel;
      phase       = {1'b0, state_ff.divCount} & (period - 8'h01);
      scaledPhase = {phase, 2'b00};
      case (dutySel)
         2'h0: begin
            // constant low, also in the undivided mode
            threshold = 10'h000;
         end
         2'h1: begin
            // a quarter of the period high
            threshold = {2'b00, period};
         end
         2'h2: begin
            // half the period high
            threshold = {1'b0, period, 1'b0};
         end
         2'h3: begin
            // three quarters of the period high
            threshold = {1'b0, period, 1'b0} + {2'b00, period};
         end
         default: begin
            threshold = 10'h000;
         end
      endcase
      refNext = (scaledPhase < threshold);
      // a two-cycle period cannot hold a quarter of a cycle; the odd
      // duty codes fall back to half, which is as close as one edge
      // per system clock allows
      if ((divSel == `REFCLK_DIV_BY_TWO) && (dutySel != `REFCLK_DUTY_ZERO)) begin
         refNext = (phase == 8'h00);
      end
      // undivided: the system clock itself, unless duty code is zero
      bypassNext = (divSel == `REFCLK_DIV_BYPASS) &&
                   (dutySel != `REFCLK_DUTY_ZERO);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // with ce low nothing moves, so every output keeps its level except an undivided clock output, held low
   always_comb begin
      nxt_state = state_ff;
      if (ce) begin
         // counter runs only while enabled, cleared otherwise
         if (moduleEn) begin
            nxt_state.divCount = state_ff.divCount + 7'h01;
         end else begin
            nxt_state.divCount = 7'h00;
         end
         // quarter clock generator always runs on the system clock
         nxt_state.quarterCount = state_ff.quarterCount + 2'h1;
         // no divided clock at all while the module is disabled
         nxt_state.refLevel = moduleEn && refNext;
         nxt_state.bypass   = moduleEn && bypassNext;
         nxt_state.slew     = slewBit;
         // pin arbitration: crystal, then quarter clock, then reference
         if (xtalAny) begin
            // pin is an oscillator input: never driven from here
            nxt_state.pinOeN    = 1'b1;
            nxt_state.pinLevel  = 1'b0;
            nxt_state.pinBypass = 1'b0;
         end else if (quarterEn) begin
            // quarter-rate clock overrides the reference output
            nxt_state.pinOeN    = 1'b0;
            nxt_state.pinLevel  = quarterLevel;
            nxt_state.pinBypass = 1'b0;
         end else if (pinRouteEn) begin
            // reference routed to the pin
            nxt_state.pinOeN    = 1'b0;
            nxt_state.pinLevel  = moduleEn && refNext;
            nxt_state.pinBypass = moduleEn && bypassNext;
         end else begin
            // pin left to its other functions
            nxt_state.pinOeN    = 1'b1;
            nxt_state.pinLevel  = 1'b0;
            nxt_state.pinBypass = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // the system clock is the only clock of the divider
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff        <= '0;
         state_ff.pinOeN <= 1'b1;   // pin released out of reset
         state_ff.slew   <= 1'b1;   // slew limiting on out of reset
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   // read back of what the pin and divider really do, since straps
   // may override the control register without software knowing
   assign pinCarriesRef = pinRouteEn && !xtalAny && !quarterEn;

   always_comb begin
      statusWord                              = 8'h00;
      statusWord[`REFCLK_ST_LEVEL_BIT]   = state_ff.refLevel;
      statusWord[`REFCLK_ST_PINREF_BIT]  = pinCarriesRef;
      statusWord[`REFCLK_ST_QUARTER_BIT] = quarterEn;
      statusWord[`REFCLK_ST_XTAL_BIT]    = xtalAny;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the undivided mode cannot come from a flop clocked by the same
   // clock, so it is a glitch-prone mux onto the clock itself; gating
   // with ce keeps it still while the block sleeps
   assign modulatorClock       = state_ff.bypass ? (clk & ce) : state_ff.refLevel;
   assign referenceClockPinOut = state_ff.pinBypass ? (clk & ce) : state_ff.pinLevel;
   assign referenceClockPinOeN = state_ff.pinOeN;
   assign slewLimitEnable      = state_ff.slew;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking assertClk @(posedge clk);
   endclocking
   default disable iff (reset);

   // one enabled step of the divider
   sequence seq_count_step;
      ce && moduleEn;
   endsequence

   // the cycle at which the block goes to sleep
   sequence seq_enter_sleep;
      ce ##1 !ce;
   endsequence

   // an enabled step with crystal straps active
   sequence seq_xtal_step;
      ce && xtalAny;
   endsequence

   // an enabled step with the quarter clock owning the pin
   sequence seq_quarter_step;
      ce && !xtalAny && quarterEn;
   endsequence

   // counter advances by one per enabled system clock
   chk_counter_step: assert property (
      seq_count_step |=> (state_ff.divCount == $past(state_ff.divCount) + 7'h01))
      else $error("divider counter did not advance by one");

   // disabled module produces no clock and holds its counter cleared
   chk_disabled_quiet: assert property (
      (ce && !moduleEn) |=> (!state_ff.refLevel && !state_ff.bypass &&
                             (state_ff.divCount == 7'h00)))
      else $error("divided clock present while module disabled");

   // nothing moves while the clock enable is low
   chk_sleep_frozen: assert property (
      !ce |=> $stable(state_ff))
      else $error("state changed while asleep");

   // levels held from the moment sleep begins
   chk_sleep_hold: assert property (
      seq_enter_sleep |=> ($stable(state_ff.refLevel) && $stable(state_ff.pinLevel)))
      else $error("output level changed on entry to sleep");

   // crystal modes release the pin
   chk_xtal_release: assert property (
      seq_xtal_step |=> state_ff.pinOeN)
      else $error("pin driven while a crystal mode owns it");

   // quarter clock drives the pin with its own level
   chk_quarter_drive: assert property (
      seq_quarter_step |=> (!state_ff.pinOeN &&
                            (state_ff.pinLevel == $past(quarterLevel))))
      else $error("quarter clock not on the pin");

   // output enable clear keeps the reference off the pin
   chk_route_off: assert property (
      (ce && !xtalAny && !quarterEn && !pinRouteEn) |=> state_ff.pinOeN)
      else $error("pin driven with routing disabled");

   // slew control follows its control bit
   chk_slew_follow: assert property (
      ce |=> (state_ff.slew == $past(slewBit)))
      else $error("slew output does not follow its control bit");

endmodule // reference_clock_divider

// *** verification/refclk_pin_sink.sv ***
`timescale 1ns/1ns

// ----------
// load on the shared pin; released pin is pulled low
// ----------
module refclk_pin_sink (
   input  wire logic pinOut,
   input  wire logic pinOeN,
   output logic      pinLevel,
   output int        edges
);
   assign pinLevel = pinOeN ? 1'b0 : pinOut; // pull-down, never a stale level
   initial edges = 0;
   // counts every clock the load receives
   always @(posedge pinLevel) edges <= edges + 1;
endmodule // refclk_pin_sink

// *** verification/testbench.sv ***
`timescale 1ns/1ns

module testbench;
   logic        clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, quarter = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [2:0]  xtal = 0;  // low-power, standard, high-speed straps
   logic        pready, pslverr, e, pinOut, pinOeN, slew, modClk, pinLevel, v;
   int          num_errors = 0, checks_done = 0, per, hi, k, edges, e0;

   always #25 clk = ~clk; // 20 MHz

   reference_clock_divider dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lowPowerCrystalMode(xtal[0]), .standardCrystalMode(xtal[1]),
      .highSpeedCrystalMode(xtal[2]), .quarterClockOutputEnable(quarter),
      .referenceClockPinOut(pinOut), .referenceClockPinOeN(pinOeN),
      .slewLimitEnable(slew), .modulatorClock(modClk));
   refclk_pin_sink load (.pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel), .edges(edges));

   // ----------
   // bench tasks
   // ----------
   task stop_test;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer; held until pready is seen at a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      q = prdata; e = pslverr;
      psel <= 0; penable <= 0;
      if (n == 50) begin num_errors++; stop_test(); end
      repeat (3) @(negedge clk); // let outputs settle
   endtask
   // period and high time of pin (1) or modulator feed (0), sampled mid-cycle
   task meas(input bit pin);
      int n, r;
      logic p, s;
      r = 0; per = 0; hi = 0; p = 1;
      for (n = 0; n < 700 && r < 2; n++) begin
         @(negedge clk);
         s = pin ? pinLevel : modClk;
         if (s && !p) r++;
         if (r == 1) begin per++; hi += s; end
         p = s;
      end
      if (r < 2) begin num_errors++; stop_test(); end
   endtask

   initial begin
      repeat (10) @(posedge clk);
      reset <= 0;
      apb(0, 12'h000, 0);
      chk(q, 32'h30);
      chk(slew, 1);
      chk(pinOeN, 1);
      apb(0, 12'h008, 0);
      chk(e, 1);
      $display("register test done");
      for (k = 1; k < 8; k++) begin
         apb(1, 12'h000, 32'hd0 | k);
         meas(0);
         chk(per, 1 << k);
         chk(hi, 1 << (k - 1));
      end
      $display("divider test done");
      for (k = 1; k < 4; k++) begin
         apb(1, 12'h000, 32'hc2 | (k << 3));
         meas(1);
         chk(per, 4);
         chk(hi, k);
      end
      apb(1, 12'h000, 32'hc2);
      e0 = edges;
      repeat (20) @(negedge clk);
      chk(edges, e0);
      apb(1, 12'h000, 32'h52);
      repeat (20) @(negedge clk);
      chk(modClk, 0);
      apb(1, 12'h000, 32'h90);
      @(posedge clk) #5 chk(modClk, 1);
      @(negedge clk) chk(modClk, 0);
      apb(1, 12'h000, 32'h80);
      @(posedge clk) #5 chk(modClk, 0);
      $display("duty test done");
      apb(1, 12'h000, 32'hd3);
      @(posedge clk) ce <= 0;
      @(negedge clk) v = modClk;
      repeat (30) @(negedge clk);
      chk(modClk, v);
      @(posedge clk) ce <= 1;
      meas(0);
      chk(per, 8);
      $display("sleep test done");
      for (k = 0; k < 3; k++) begin
         @(posedge clk) xtal <= 3'h1 << k;
         repeat (6) @(negedge clk);
         chk(pinOeN, 1);
      end
      @(posedge clk) xtal <= 0;
      quarter <= 1;
      repeat (6) @(negedge clk);
      meas(1);
      chk(per, 4);
      chk(hi, 2);
      apb(1, 12'h000, 32'h00);
      chk(slew, 0);
      chk(pinOeN, 0);
      $display("pin test done");
      @(posedge clk) reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      apb(0, 12'h000, 0);
      chk(q, 32'h30);
      chk(slew, 1);
      $display("reset test done");
      stop_test();
   end
endmodule // testbench
